// ===== common/maf_defs.svh
// constants of the moving-average filter: offsets, fields, resets, timing
// assumes a 25 MHz clock and a 32-bit APB register bus
// Operation
// - after power-up the state LED is red briefly, then green
// - each accepted register write after the red phase blinks the state LED off briefly
// - until the window is full, output the mean of samples so far
// - an out-of-range sample flags overflow and restarts the sample count
// - a full window slides: each new sample replaces the oldest
// - averaging time resets to one second
// - sample every 30 ms below 10 s averaging, else every 0.5 s
// - window depths 6,13,20,27,34,103,172,20,30,40 per time code
// - software chooses how the output behaves on overflow
// - with overflow handling on, low input gives programmed low output
// - with overflow handling on, high input gives programmed high output
// - averaging time code 0..9 selects 0.2 s up to 20 s
// - status bit 12 is one until a full window has been gathered
// - status bit 13 is one while upper range overflow is present
`ifndef MAF_DEFS_SVH
`define MAF_DEFS_SVH
// ==========================================
// register byte offsets
`define OFS_AVG     8'h00
`define OFS_OVF     8'h04
`define OFS_LO_LIM  8'h08
`define OFS_HI_LIM  8'h0C
`define OFS_OUT_LO  8'h10
`define OFS_OUT_HI  8'h14
`define OFS_STATUS  8'h18
`define OFS_MEAN    8'h1C
`define OFS_IRQ_ST  8'h20
`define OFS_IRQ_MSK 8'h24
// ==========================================
// fields and reset values
`define ST_FILLING  12
`define ST_UPPER    13
`define ST_LOWER    0
`define AVG_RST     4'h4
`define AVG_MAX     4'h9
`define AVG_SLOW    4'h7
`define DEPTH_MAX   172
`define DEPTH_TABLE {8'd40, 8'd30, 8'd20, 8'd172, 8'd103, \
                     8'd34, 8'd27, 8'd20, 8'd13, 8'd6}
// ==========================================
// timing
`define CLK_NS      40
`define FAST_NS     30000000
`define SLOW_NS     500000000
`define RED_NS      200000000
`define BLINK_NS    50000000
`define FAST_CYC    (`FAST_NS / `CLK_NS)
`define SLOW_CYC    (`SLOW_NS / `CLK_NS)
`define RED_CYC     (`RED_NS / `CLK_NS)
`define BLINK_CYC   (`BLINK_NS / `CLK_NS)
`endif

// ===== common/maf_pkg.sv
// types of the moving-average filter
// assumes maf_defs.svh for all sizes
package maf_pkg;
    typedef enum logic [1:0] {LED_RED, LED_GREEN, LED_OFF} led_t;

    // apb request from master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // apb answer to master
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    // sample from the acquisition front end
    typedef struct packed {
        logic               valid;
        logic signed [15:0] data;
    } sample_t;
endpackage

// ===== design/moving_average_overflow_filter.sv
// moving-average filter with overflow substitution and state LED
// assumes front end on clk, answering each strobe with one valid sample
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`include "maf_defs.svh"
module moving_average_overflow_filter #(
    parameter int FAST_CYC  = `FAST_CYC,
    parameter int SLOW_CYC  = `SLOW_CYC,
    parameter int RED_CYC   = `RED_CYC,
    parameter int BLINK_CYC = `BLINK_CYC,
    parameter int DEPTH     = `DEPTH_MAX
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // register bus
    input  wire maf_pkg::apb_req_t apb_req,
    output      maf_pkg::apb_rsp_t apb_rsp,
    // front end
    input  wire maf_pkg::sample_t  sample_in,
    output      logic              sample_strobe,
    // results
    output      logic [15:0]       out_value,
    output      logic              irq,
    output      logic              led_red,
    output      logic              led_green
);
    import maf_pkg::*;

    initial begin
        // blink must last three cycles at least, the blink check needs it
        if (DEPTH < `DEPTH_MAX || DEPTH > 255 || FAST_CYC < 2 ||
            SLOW_CYC < 2 || RED_CYC < 1 || BLINK_CYC < 3 ||
            SLOW_CYC >= (1 << 24) || RED_CYC >= (1 << 24) ||
            BLINK_CYC >= (1 << 24) || FAST_CYC >= (1 << 24))
            $error("moving_average_overflow_filter: bad parameters");
    end

    // ==========================================
    // state
    typedef struct packed {
        logic [3:0]              avg;
        logic                    ovf_en;
        logic signed [15:0]      lo_lim;
        logic signed [15:0]      hi_lim;
        logic signed [15:0]      out_lo;
        logic signed [15:0]      out_hi;
        logic [DEPTH-1:0][15:0]  win;
        logic signed [23:0]      sum;
        logic [7:0]              cnt;
        logic [7:0]              idx;
        logic                    upper;
        logic                    lower;
        logic [23:0]             tick;
        logic                    strobe;
        logic signed [15:0]      out;
        logic [3:0]              irq_st;
        logic [3:0]              irq_msk;
        logic                    irq;
        led_t                    led;
        logic [23:0]             led_tmr;
        apb_rsp_t                rsp;
        logic                    led_r;
        logic                    led_g;
        logic                    first;
    } state_t;

    state_t st_q, st_d;

    localparam logic [79:0] DEPTHS = `DEPTH_TABLE;

    // window depth for a time code, with no guard against codes above 9
    function automatic logic [7:0] depth_of(input logic [3:0] code);
        logic [7:0] d;
        d = DEPTHS[8*code +: 8];
        return d;
    endfunction

    logic [7:0]         n_sel;
    logic               wr_ok;
    logic               rd_ok;
    logic               in_rng;
    logic signed [15:0] x;
    logic signed [23:0] mean;
    logic [31:0]        status;

    assign n_sel = depth_of(st_q.avg);
    assign wr_ok = apb_req.psel & apb_req.penable & st_q.rsp.pready &
                   apb_req.pwrite;
    assign rd_ok = apb_req.psel & apb_req.penable & st_q.rsp.pready &
                   ~apb_req.pwrite;
    assign x     = sample_in.data;
    assign in_rng = (x >= st_q.lo_lim) && (x <= st_q.hi_lim);

    // ==========================================
    // next state
    always_comb begin
        logic [23:0] per;
        logic [7:0]  ncnt;
        logic [3:0]  ev;
        logic [3:0]  wavg;
        per    = 24'h0;
        ncnt   = 8'h0;
        ev     = 4'h0;
        wavg   = 4'h0;
        st_d   = st_q;
        mean   = 24'sh0;
        status = 32'h0;

        // sample pacing: slow rate for 10 s and above
        per = (st_q.avg >= `AVG_SLOW) ? SLOW_CYC[23:0]
                                      : FAST_CYC[23:0];
        st_d.strobe = 1'b0;
        if (st_q.tick >= per - 24'h1) begin
            st_d.tick   = 24'h0;
            st_d.strobe = 1'b1;
        end else begin
            st_d.tick = st_q.tick + 24'h1;
        end

        // averaging on each valid sample
        if (sample_in.valid) begin
            if (!in_rng) begin
                st_d.cnt   = 8'h0;
                st_d.idx   = 8'h0;
                st_d.sum   = 24'sh0;
                st_d.lower = (x < st_q.lo_lim);
                st_d.upper = (x > st_q.hi_lim);
                ev[1]      = st_d.lower;
                ev[2]      = st_d.upper;
                if (st_q.ovf_en && st_d.lower)
                    st_d.out = st_q.out_lo;
                else if (st_q.ovf_en)
                    st_d.out = st_q.out_hi;
            end else begin
                st_d.lower = 1'b0;
                st_d.upper = 1'b0;
                if (st_q.cnt < n_sel) begin
                    st_d.sum = st_q.sum + 24'(x);
                    ncnt     = st_q.cnt + 8'h1;
                    ev[3]    = (ncnt == n_sel);
                end else begin
                    // drop the oldest, add the newest
                    st_d.sum = st_q.sum + 24'(x) -
                               24'($signed(st_q.win[st_q.idx]));
                    ncnt     = st_q.cnt;
                end
                st_d.cnt = ncnt;
                st_d.win[st_q.idx] = x;
                st_d.idx = (st_q.idx + 8'h1 >= n_sel) ? 8'h0
                                                      : st_q.idx + 8'h1;
                // divider is wide, but runs once per sample only
                mean     = st_d.sum / $signed({16'h0, ncnt});
                st_d.out = mean[15:0];
                ev[0]    = 1'b1;
            end
        end

        // status word as software sees it
        status[`ST_FILLING] = (st_q.cnt < n_sel);
        status[`ST_UPPER]   = st_q.upper;
        status[`ST_LOWER]   = st_q.lower;

        // apb: answer one cycle after setup
        st_d.rsp.pready  = apb_req.psel & ~apb_req.penable;
        st_d.rsp.pslverr = 1'b0;
        st_d.rsp.prdata  = 32'h0;
        if (apb_req.psel && !apb_req.penable) begin
            case (apb_req.paddr)
                `OFS_AVG:     st_d.rsp.prdata = {28'h0, st_q.avg};
                `OFS_OVF:     st_d.rsp.prdata = {31'h0, st_q.ovf_en};
                `OFS_LO_LIM:  st_d.rsp.prdata = {16'h0, st_q.lo_lim};
                `OFS_HI_LIM:  st_d.rsp.prdata = {16'h0, st_q.hi_lim};
                `OFS_OUT_LO:  st_d.rsp.prdata = {16'h0, st_q.out_lo};
                `OFS_OUT_HI:  st_d.rsp.prdata = {16'h0, st_q.out_hi};
                `OFS_STATUS:  st_d.rsp.prdata = status;
                `OFS_MEAN:    st_d.rsp.prdata = {16'h0, st_q.out};
                `OFS_IRQ_ST:  st_d.rsp.prdata = {28'h0, st_q.irq_st};
                `OFS_IRQ_MSK: st_d.rsp.prdata = {28'h0, st_q.irq_msk};
                default:      st_d.rsp.pslverr = 1'b1;
            endcase
        end
        if (rd_ok && apb_req.paddr == `OFS_IRQ_ST)
            st_d.irq_st = 4'h0;
        if (wr_ok) begin
            case (apb_req.paddr)
                `OFS_AVG: begin
                    wavg = apb_req.pwdata[3:0];
                    // codes above 9 are ignored, upper bits included
                    if (apb_req.pwdata <= {28'h0, `AVG_MAX} &&
                        wavg != st_q.avg) begin
                        st_d.avg = wavg;
                        st_d.cnt = 8'h0;
                        st_d.idx = 8'h0;
                        st_d.sum = 24'sh0;
                        st_d.win = '0;
                    end
                end
                `OFS_OVF:     st_d.ovf_en  = apb_req.pwdata[0];
                `OFS_LO_LIM:  st_d.lo_lim  = apb_req.pwdata[15:0];
                `OFS_HI_LIM:  st_d.hi_lim  = apb_req.pwdata[15:0];
                `OFS_OUT_LO:  st_d.out_lo  = apb_req.pwdata[15:0];
                `OFS_OUT_HI:  st_d.out_hi  = apb_req.pwdata[15:0];
                `OFS_IRQ_MSK: st_d.irq_msk = apb_req.pwdata[3:0];
                default: ;
            endcase
        end
        // events set after the read clear, so set wins
        st_d.irq_st = st_d.irq_st | ev;
        st_d.irq    = |(st_d.irq_st & st_d.irq_msk);

        // state LED
        case (st_q.led)
            LED_RED: begin
                if (st_q.led_tmr >= RED_CYC[23:0] - 24'h1) begin
                    st_d.led     = LED_GREEN;
                    st_d.led_tmr = 24'h0;
                end else begin
                    st_d.led_tmr = st_q.led_tmr + 24'h1;
                end
            end
            LED_OFF: begin
                if (st_q.led_tmr >= BLINK_CYC[23:0] - 24'h1) begin
                    st_d.led     = LED_GREEN;
                    st_d.led_tmr = 24'h0;
                end else begin
                    st_d.led_tmr = st_q.led_tmr + 24'h1;
                end
            end
            default: st_d.led = LED_GREEN;
        endcase
        if (wr_ok && st_q.led != LED_RED) begin
            st_d.led     = LED_OFF;
            st_d.led_tmr = 24'h0;
        end
        // lamp drives registered so the pins never glitch on a decode
        st_d.led_r = (st_d.led == LED_RED);
        st_d.led_g = (st_d.led == LED_GREEN);
        st_d.first = 1'b0;
    end

    // ==========================================
    // registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q        <= '0;
            st_q.avg    <= `AVG_RST;
            st_q.hi_lim <= 16'h7FFF;
            st_q.lo_lim <= 16'h8000;
            st_q.led    <= LED_RED;
            st_q.led_r  <= 1'b1;
            st_q.first  <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign apb_rsp       = st_q.rsp;
    assign sample_strobe = st_q.strobe;
    assign out_value     = st_q.out;
    assign irq           = st_q.irq;
    assign led_red       = st_q.led_r;
    assign led_green     = st_q.led_g;

    // ==========================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence good_smp;
        sample_in.valid && in_rng;
    endsequence
    sequence bad_smp;
        sample_in.valid && !in_rng;
    endsequence

    led_power_up_a: assert property ($fell(led_red) |-> led_green)
        else $error("red LED did not hand over to green");
    write_blink_a: assert property (wr_ok && !led_red |=> !led_green [*3])
        else $error("write not confirmed by LED blink");
    fill_count_a: assert property (good_smp and st_q.cnt < n_sel
        and !wr_ok |=> st_q.cnt == $past(st_q.cnt) + 8'h1)
        else $error("fill count did not advance");
    ovf_restart_a: assert property (bad_smp |=> st_q.cnt == 8'h0)
        else $error("overflow did not restart count");
    slide_hold_a: assert property (good_smp and st_q.cnt == n_sel
        and !wr_ok |=> st_q.cnt == $past(n_sel))
        else $error("full window lost its depth");
    reset_time_a: assert property (st_q.first |-> st_q.avg == 4'h4)
        else $error("averaging time not one second after reset");
    strobe_gap_a: assert property (sample_strobe |=> !sample_strobe)
        else $error("sample strobes back to back");
    low_subst_a: assert property (bad_smp and st_q.ovf_en and
        x < st_q.lo_lim |=> out_value == $past(st_q.out_lo))
        else $error("low substitute value not shown");
    high_subst_a: assert property (bad_smp and st_q.ovf_en and
        x > st_q.hi_lim |=> out_value == $past(st_q.out_hi))
        else $error("high substitute value not shown");
    upper_flag_a: assert property (bad_smp and x > st_q.hi_lim
        |=> status[`ST_UPPER])
        else $error("upper overflow status missing");
    time_clear_a: assert property (wr_ok && apb_req.paddr == `OFS_AVG &&
        apb_req.pwdata <= 32'h9 && apb_req.pwdata[3:0] != st_q.avg
        |=> st_q.cnt == 8'h0 && status[`ST_FILLING])
        else $error("time change did not restart window");
endmodule

// ===== verif/maf_front_end.sv
// front-end model: answers each sample strobe with one sample
// assumes the filter's clock; the bench sets value, lag and enable
`timescale 1ns/10ps
module maf_front_end (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               nrst,
    // control from bench and filter
    input  wire logic               en,
    input  wire logic               strobe,
    input  wire logic [3:0]         lag,
    input  wire logic signed [15:0] next_val,
    // sample to filter
    output      maf_pkg::sample_t   sample
);
    import maf_pkg::*;
    logic [4:0] wait_q;
    // ========
    // lag countdown; idle data toggles so a stale value never looks good
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_q <= 5'h00;
            sample <= '0;
        end else begin
            sample.valid <= 1'b0;
            sample.data <= ~sample.data;
            if (!en) begin
                wait_q <= 5'h00;
            end else if (strobe) begin
                wait_q <= {1'b0, lag} + 5'h01;
            end else if (wait_q == 5'h01) begin
                sample.valid <= 1'b1;
                sample.data <= next_val;
                wait_q <= 5'h00;
            end else if (wait_q != 5'h00) begin
                wait_q <= wait_q - 5'h01;
            end
        end
    end
endmodule

// ===== verif/moving_average_overflow_filter_bench.sv
// self-checking bench of the moving-average filter
// assumes shortened counts: strobes 20/40 cycles, red 10, blink 5
`timescale 1ns/10ps
`include "maf_defs.svh"
module moving_average_overflow_filter_bench;
    import maf_pkg::*;
    localparam int FAST = 20;
    localparam int SLOW = 40;
    logic               clk = 1'b0;
    logic               nrst = 1'b0;
    apb_req_t           req = '0;
    apb_rsp_t           rsp;
    sample_t            smp;
    logic               strobe, irq, led_red, led_green, err;
    logic               fe_en = 1'b0;
    logic [15:0]        out_value, sub_lo, sub_hi, exp_out = 16'h0000;
    logic [3:0]         lag = 4'h0;
    logic signed [15:0] nxt = 16'sh0000;
    logic [31:0]        rd;
    logic               ovf_en = 1'b0, up_ovf = 1'b0, lo_ovf = 1'b0;
    logic               cmp = 1'b0;
    int seed = 70470;
    int fail_count = 0;
    int total_checks = 0;
    int depth[10] = '{6, 13, 20, 27, 34, 103, 172, 20, 30, 40};
    int win[$];
    int sum = 0, nseen = 0, v, code = 4, lo_lim = -32768, hi_lim = 32767;

    moving_average_overflow_filter #(.FAST_CYC(FAST), .SLOW_CYC(SLOW),
        .RED_CYC(10), .BLINK_CYC(5), .DEPTH(172)) dut_u (.clk(clk),
        .nrst(nrst), .apb_req(req), .apb_rsp(rsp), .sample_in(smp),
        .sample_strobe(strobe), .out_value(out_value), .irq(irq),
        .led_red(led_red), .led_green(led_green));
    maf_front_end fe_u (.clk(clk), .nrst(nrst), .en(fe_en),
        .strobe(strobe), .lag(lag), .next_val(nxt), .sample(smp));

    // ========
    // clock, random stimulus to the front end
    always #20 clk = ~clk;
    always @(posedge clk) begin
        nxt <= 16'($random(seed) % 3000);
        lag <= 4'($random(seed));
    end

    // ========
    // reference model: sliding window, compared one edge after each sample
    always @(posedge clk) begin
        if (cmp) check(out_value, exp_out);
        cmp = 1'b0;
        if (nrst && smp.valid === 1'b1) begin
            nseen++;
            cmp = 1'b1;
            v = $signed(smp.data);
            if (v < lo_lim || v > hi_lim) begin
                win.delete();
                sum = 0;
                up_ovf = v > hi_lim;
                lo_ovf = v < lo_lim;
                if (ovf_en) exp_out = up_ovf ? sub_hi : sub_lo;
            end else begin
                up_ovf = 1'b0;
                lo_ovf = 1'b0;
                win.push_back(v);
                sum += v;
                if (win.size() > depth[code]) sum -= win.pop_front();
                exp_out = 16'(sum / win.size());
            end
        end
    end

    // ========
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen,
                     want);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1) @(posedge clk);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        // idle edge: a following call never re-drives psel in this step
        @(posedge clk);
    endtask

    // write, check the led blink, keep the model's settings in step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        @(posedge clk);
        check(led_green, 1'b0);
        if (a == `OFS_AVG && d < 10 && d != code) begin
            code = int'(d);
            win.delete();
            sum = 0;
        end
        if (a == `OFS_LO_LIM) lo_lim = $signed(d[15:0]);
        if (a == `OFS_HI_LIM) hi_lim = $signed(d[15:0]);
        if (a == `OFS_OUT_LO) sub_lo = d[15:0];
        if (a == `OFS_OUT_HI) sub_hi = d[15:0];
        if (a == `OFS_OVF) ovf_en = d[0];
    endtask

    // spacing between two strobes in cycles
    task automatic strobe_gap(input int want);
        int n = 1;
        while (strobe !== 1'b1) @(posedge clk);
        @(posedge clk);
        while (strobe !== 1'b1) begin
            n++;
            @(posedge clk);
        end
        check(n, want);
    endtask

    // let n samples through, then drop the one that may be in flight
    task automatic feed(input int n);
        int stop = nseen + n;
        fe_en <= 1'b1;
        while (nseen < stop) @(posedge clk);
        fe_en <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // ========
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        check(led_red, 1'b1);
        repeat (12) @(posedge clk);
        check({led_red, led_green}, 2'b01);
        apb(1'b0, `OFS_AVG, 32'h0);
        check(rd, 32'h4);
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        for (int c = 0; c < 10; c++) begin
            wr(`OFS_AVG, 32'(c));
            apb(1'b0, `OFS_STATUS, 32'h0);
            check(rd[12], 1'b1);
            strobe_gap(c > 6 ? SLOW : FAST);
            feed(depth[c] + 3);
            apb(1'b0, `OFS_STATUS, 32'h0);
            check(rd[12], 1'b0);
        end
        wr(`OFS_AVG, 32'h13);
        apb(1'b0, `OFS_AVG, 32'h0);
        check(rd, 32'h9);
        wr(`OFS_LO_LIM, 32'hFC18);
        wr(`OFS_HI_LIM, 32'h03E8);
        wr(`OFS_OUT_LO, 32'h1111);
        wr(`OFS_OUT_HI, 32'h2222);
        for (int e = 1; e >= 0; e--) begin
            wr(`OFS_OVF, 32'(e));
            feed(40);
            apb(1'b0, `OFS_STATUS, 32'h0);
            check({rd[13], rd[0]}, {up_ovf, lo_ovf});
        end
        wr(`OFS_LO_LIM, 32'h8000);
        wr(`OFS_HI_LIM, 32'h7FFF);
        wr(`OFS_IRQ_MSK, 32'h1);
        apb(1'b0, `OFS_IRQ_ST, 32'h0);
        feed(1);
        check(irq, 1'b1);
        apb(1'b0, `OFS_IRQ_ST, 32'h0);
        check(rd[0], 1'b1);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        wr(`OFS_IRQ_MSK, 32'h0);
        feed(1);
        check(irq, 1'b0);
        close_out();
    end

    // ========
    // watchdog: about four times the expected 15000 cycles
    initial begin
        #2400000;
        fail_count++;
        close_out();
    end
endmodule
